/* File: supervisor_defs.svh */
`ifndef SUPERVISOR_DEFS_SVH
`define SUPERVISOR_DEFS_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define MSC_OFS 8'h00
`define WDC_OFS 8'h04
`define STAT_OFS 8'h08
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MSC_MODE_LO 0
`define MSC_SUPP_BIT 2
`define MSC_DSEL_BIT 3
`define WDC_PER_LO 0
`define WDC_TYPE_BIT 3
`define WDC_FS_BIT 4
`define WDC_PAR_BIT 15
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define WDC_RST 5'h00
`define SUPP_RST 1'b0
`define DSEL_RST 1'b0
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_KHZ 64'd250000
`define WD_MS0 64'd10
`define WD_MS1 64'd20
`define WD_MS2 64'd50
`define WD_MS3 64'd100
`define WD_MS4 64'd200
`define WD_MS5 64'd500
`define WD_MS6 64'd1000
`define WD_MS7 64'd10000
`define LW_MS 64'd200
`define RF_US 64'd10
`define RD1_MS 64'd10
`define RD2_MS 64'd1
`endif

/* File: supervisor_pkg.sv */
package supervisor_pkg;
	// device operating modes
	typedef enum logic [2:0] {
		M_INIT, M_NORMAL, M_STOP, M_SLEEP, M_RESTART, M_FAILSAFE
	} dev_mode_t;
	// watchdog phase
	typedef enum logic [1:0] {WD_OFF, WD_LONG, WD_RUN} wd_state_t;
	// mode field values written by software
	typedef enum logic [1:0] {MW_NORMAL, MW_SLEEP, MW_STOP, MW_SOFTRST} mode_wr_t;
	// watchdog configuration as stored
	typedef struct packed {
		logic fail_safe;
		logic win_type;
		logic [2:0] period;
	} watchdog_type_select_t;
endpackage : supervisor_pkg

/* File: reset_and_watchdog_supervisor.sv */
// Design decisions made here: the strobed register port and the address map.
`include "supervisor_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module reset_and_watchdog_supervisor
	import supervisor_pkg::*;
#(
	// one entry per period setting, converted one by one, index = setting
	parameter logic [7:0][31:0] WD_PERIOD_CYC = {
		32'(`WD_MS7 * `CLK_KHZ), 32'(`WD_MS6 * `CLK_KHZ), 32'(`WD_MS5 * `CLK_KHZ), 32'(`WD_MS4 * `CLK_KHZ),
		32'(`WD_MS3 * `CLK_KHZ), 32'(`WD_MS2 * `CLK_KHZ), 32'(`WD_MS1 * `CLK_KHZ), 32'(`WD_MS0 * `CLK_KHZ)
	},
	parameter logic [31:0] LW_CYC = 32'(`LW_MS * `CLK_KHZ),
	parameter logic [31:0] RF_CYC = 32'(`RF_US * `CLK_KHZ / 64'd1000),
	parameter logic [31:0] RD1_CYC = 32'(`RD1_MS * `CLK_KHZ),
	parameter logic [31:0] RD2_CYC = 32'(`RD2_MS * `CLK_KHZ)
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic [7:0] addr_in,
	input wire logic [15:0] wr_data_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	output logic [15:0] rd_data_out,
	input wire logic main_regulator_output_above_thr_in,
	input wire logic main_regulator_output_above_1v_in,
	input wire logic supply_sense_input_above_por_in,
	input wire logic sw_dev_mode_in,
	output logic reset_out_low_out
);
	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (LW_CYC == 32'h0 || RF_CYC == 32'h0 || RD1_CYC == 32'h0 || RD2_CYC == 32'h0)
		$error("timing counts must be at least one cycle");

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic [3:0] pin_meta_q;
	logic [3:0] pin_sync_q;
	logic vcc_ok;
	logic can_pull;
	logic sw_dev;
	// pins are async to clk_in: two stages before use
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			// the 1V and POR headroom bits start high so the pin cannot blip high after reset
			pin_meta_q <= 4'h6;
			pin_sync_q <= 4'h6;
		end else begin
			pin_meta_q <= {sw_dev_mode_in, supply_sense_input_above_por_in, main_regulator_output_above_1v_in, main_regulator_output_above_thr_in};
			pin_sync_q <= pin_meta_q;
		end
	end
	assign vcc_ok = pin_sync_q[0];
	assign can_pull = pin_sync_q[1] & pin_sync_q[2];
	assign sw_dev = pin_sync_q[3];

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	logic msc_wr;
	logic wdc_wr;
	logic par_ok;
	logic soft_rst;
	mode_wr_t mode_req;
	dev_mode_t mode_q;
	wd_state_t wd_st_q;
	watchdog_type_select_t cfg_q;
	watchdog_type_select_t cfg_new;
	logic supp_q;
	logic dsel_q;
	assign msc_wr = wr_en_in && addr_in == `MSC_OFS;
	assign wdc_wr = wr_en_in && addr_in == `WDC_OFS;
	// reserved bits are part of the xor on purpose
	assign par_ok = ~^wr_data_in;
	assign mode_req = mode_wr_t'(wr_data_in[`MSC_MODE_LO+:2]);
	assign soft_rst = msc_wr && mode_req == MW_SOFTRST
		&& (mode_q == M_NORMAL || mode_q == M_STOP);
	assign cfg_new = {wr_data_in[`WDC_FS_BIT], wr_data_in[`WDC_TYPE_BIT], wr_data_in[`WDC_PER_LO+:3]};

	// ----------------------------------------------------------------
	// watchdog timing
	// ----------------------------------------------------------------
	logic [31:0] wd_cnt_q;
	logic [31:0] per_cyc;
	logic [31:0] closed_cyc;
	logic [31:0] open_end_cyc;
	logic [7:0][31:0] closed_tab;
	logic [7:0][31:0] end_tab;
	logic trig;
	logic watchdog_failure_flags;
	logic in_closed;
	// window bounds per period setting, constants after elaboration
	for (genvar i = 0; i < 8; i++) begin : g_win
		// tiny periods leave no closed window; 1.4 periods must fit the counter
		if (WD_PERIOD_CYC[i] < 32'h5 || 64'(WD_PERIOD_CYC[i]) * 64'd7 / 64'd5 > 64'hffffffff)
			$error("watchdog period outside what the counters can serve");
		assign closed_tab[i] = 32'(64'(WD_PERIOD_CYC[i]) * 64'd3 / 64'd5);
		assign end_tab[i] = 32'(64'(WD_PERIOD_CYC[i]) * 64'd7 / 64'd5);
	end
	assign per_cyc = WD_PERIOD_CYC[cfg_q.period];
	assign closed_cyc = closed_tab[cfg_q.period];
	// period sits mid open window, so window mode ends at 1.4 periods
	assign open_end_cyc = cfg_q.win_type ? end_tab[cfg_q.period] : per_cyc;
	assign trig = wdc_wr && par_ok && wd_st_q != WD_OFF;
	assign in_closed = wd_st_q == WD_RUN && cfg_q.win_type && wd_cnt_q < closed_cyc;
	// early trigger or expiry both count as failure
	assign watchdog_failure_flags = (trig && in_closed)
		|| (wd_st_q == WD_RUN && wd_cnt_q >= open_end_cyc - 32'h1)
		|| (wd_st_q == WD_LONG && !trig && wd_cnt_q >= LW_CYC - 32'h1);
	logic wd_rst_kick;
	assign wd_rst_kick = watchdog_failure_flags && !sw_dev;

	// ----------------------------------------------------------------
	// reset output generation
	// ----------------------------------------------------------------
	logic [31:0] filt_cnt_q;
	logic [31:0] dly_cnt_q;
	logic rst_act_q;
	logic dly_sel_q;
	logic kick;
	logic rst_rel;
	logic [31:0] dly_tgt;
	assign kick = wd_rst_kick || (soft_rst && !supp_q);
	assign dly_tgt = dly_sel_q ? RD2_CYC : RD1_CYC;
	assign rst_rel = rst_act_q && !kick && vcc_ok && dly_cnt_q >= dly_tgt - 32'h1;
	// undervoltage must persist for the filter time
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			filt_cnt_q <= 32'h0;
		end else if (vcc_ok) begin
			filt_cnt_q <= 32'h0;
		end else if (filt_cnt_q < RF_CYC) begin
			filt_cnt_q <= filt_cnt_q + 32'h1;
		end
	end
	// active from power-up; delay only runs with main_regulator_output good
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rst_act_q <= 1'b1;
			dly_cnt_q <= 32'h0;
			dly_sel_q <= `DSEL_RST;
		end else if (kick || filt_cnt_q >= RF_CYC) begin
			rst_act_q <= 1'b1;
			dly_cnt_q <= 32'h0;
			dly_sel_q <= dsel_q;
		end else if (rst_act_q) begin
			if (!vcc_ok) begin
				dly_cnt_q <= 32'h0;
			end else if (rst_rel) begin
				rst_act_q <= 1'b0;
			end else begin
				dly_cnt_q <= dly_cnt_q + 32'h1;
			end
		end
	end
	// pin can only be pulled with enough supply headroom
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			reset_out_low_out <= 1'b0;
		end else begin
			reset_out_low_out <= !(rst_act_q && can_pull);
		end
	end

	// ----------------------------------------------------------------
	// mode and watchdog sequencing
	// ----------------------------------------------------------------
	logic [1:0] fail_q;
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			mode_q <= M_INIT;
			wd_st_q <= WD_OFF;
			wd_cnt_q <= 32'h0;
		end else if (soft_rst) begin
			mode_q <= M_INIT;
			wd_cnt_q <= 32'h0;
			// no pin pulse when suppressed, so start the window now
			wd_st_q <= supp_q ? WD_LONG : WD_OFF;
		end else if (watchdog_failure_flags && sw_dev) begin
			wd_st_q <= WD_LONG;
			wd_cnt_q <= 32'h0;
		end else if (watchdog_failure_flags) begin
			mode_q <= cfg_q.fail_safe ? M_FAILSAFE : M_RESTART;
			wd_st_q <= WD_OFF;
			wd_cnt_q <= 32'h0;
		end else if (trig) begin
			wd_st_q <= WD_RUN;
			wd_cnt_q <= 32'h0;
		end else if (rst_rel && (mode_q == M_INIT || mode_q == M_RESTART)) begin
			if (mode_q == M_RESTART)
				mode_q <= M_NORMAL;
			wd_st_q <= WD_LONG;
			wd_cnt_q <= 32'h0;
		end else if (msc_wr) begin
			// a mode write must not freeze the watchdog timer
			if (wd_st_q != WD_OFF)
				wd_cnt_q <= wd_cnt_q + 32'h1;
			case (mode_req)
				MW_NORMAL: begin
					if (mode_q != M_RESTART)
						mode_q <= M_NORMAL;
					if (mode_q == M_SLEEP || mode_q == M_FAILSAFE) begin
						wd_st_q <= WD_LONG;
						wd_cnt_q <= 32'h0;
					end
				end
				MW_SLEEP: begin
					if (mode_q == M_NORMAL) begin
						mode_q <= M_SLEEP;
						wd_st_q <= WD_OFF;
					end
				end
				MW_STOP: begin
					if (mode_q == M_NORMAL)
						mode_q <= M_STOP;
				end
				default: begin
				end
			endcase
		end else if (wd_st_q != WD_OFF) begin
			wd_cnt_q <= wd_cnt_q + 32'h1;
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			cfg_q <= `WDC_RST;
			supp_q <= `SUPP_RST;
			dsel_q <= `DSEL_RST;
		end else if (soft_rst) begin
			cfg_q <= `WDC_RST;
			supp_q <= `SUPP_RST;
			dsel_q <= `DSEL_RST;
		end else begin
			// bad parity changes nothing
			if (wdc_wr && par_ok && mode_q == M_NORMAL)
				cfg_q <= cfg_new;
			if (msc_wr && mode_req != MW_SOFTRST) begin
				supp_q <= wr_data_in[`MSC_SUPP_BIT];
				dsel_q <= wr_data_in[`MSC_DSEL_BIT];
			end
		end
	end

	// ----------------------------------------------------------------
	// status flags
	// ----------------------------------------------------------------
	logic frame_err_q;
	logic stat_rd;
	assign stat_rd = rd_en_in && addr_in == `STAT_OFS;
	// failure count saturates at three
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			fail_q <= 2'h0;
		end else if (soft_rst) begin
			fail_q <= 2'h0; // soft reset outranks a same-cycle failure
		end else if (wd_rst_kick) begin
			fail_q <= fail_q == 2'h3 ? 2'h3 : fail_q + 2'h1;
		end else if ((trig && !in_closed) || mode_q == M_SLEEP) begin
			fail_q <= 2'h0;
		end
	end
	// read of status clears; a new error in that cycle wins
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			frame_err_q <= 1'b0;
		end else if (wdc_wr && !par_ok) begin
			frame_err_q <= 1'b1;
		end else if (stat_rd || soft_rst) begin
			frame_err_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rd_data_out <= 16'h0;
		end else if (rd_en_in) begin
			case (addr_in)
				`MSC_OFS: rd_data_out <= {12'h0, dsel_q, supp_q, 2'h0};
				// reserved and parity positions read as zero
				`WDC_OFS: rd_data_out <= {11'h0, cfg_q};
				`STAT_OFS: rd_data_out <= {7'h0, wd_st_q, rst_act_q, frame_err_q, fail_q, mode_q};
				default: rd_data_out <= 16'h0;
			endcase
		end else begin
			rd_data_out <= 16'h0;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_parity_discard: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		wdc_wr && !par_ok && wd_st_q != WD_OFF && !watchdog_failure_flags && !rst_rel
		|=> frame_err_q && wd_cnt_q == $past(wd_cnt_q) + 32'h1)
		else $error("bad parity write not flagged");
	a_parity_keep: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		wdc_wr && !par_ok && !watchdog_failure_flags && !rst_rel |=> frame_err_q && $stable(cfg_q) && $stable(wd_st_q))
		else $error("bad parity write altered watchdog");
	a_soft_ignored: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		msc_wr && mode_req == MW_SOFTRST && mode_q != M_NORMAL && mode_q != M_STOP
		&& !watchdog_failure_flags && !rst_rel |=> $stable(mode_q))
		else $error("soft reset acted outside normal or stop");
	a_soft_init: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		soft_rst |=> mode_q == M_INIT && cfg_q == `WDC_RST && fail_q == 2'h0)
		else $error("soft reset did not reinitialise");
	a_soft_pin: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		soft_rst && !supp_q && can_pull |=> ##1 !reset_out_low_out)
		else $error("soft reset did not pull the pin");
	a_cfg_stop: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		mode_q == M_STOP && !soft_rst |=> $stable(cfg_q))
		else $error("configuration changed in stop");
	a_watchdog_failure_flags_rst: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		watchdog_failure_flags && !sw_dev && !soft_rst |=> rst_act_q && wd_st_q == WD_OFF
		&& (mode_q == M_RESTART || mode_q == M_FAILSAFE))
		else $error("watchdog failure without reset");
	a_trig_clears: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		trig && !watchdog_failure_flags && !soft_rst |=> fail_q == 2'h0 && wd_st_q == WD_RUN && wd_cnt_q == 32'h0)
		else $error("good trigger did not restart");
	a_pin_gate: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		!can_pull |=> reset_out_low_out)
		else $error("pin pulled without supply headroom");
	a_restart_long: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		rst_rel && mode_q == M_RESTART && !trig && !soft_rst |=> mode_q == M_NORMAL && wd_st_q == WD_LONG)
		else $error("restart did not resume with long window");
	a_dev_long: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		watchdog_failure_flags && sw_dev && !soft_rst |=> wd_st_q == WD_LONG && !$changed(mode_q))
		else $error("development mode failure mishandled");
	a_timeout_expiry: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		wd_st_q == WD_RUN && !cfg_q.win_type && wd_cnt_q == per_cyc - 32'h1 && !sw_dev && !soft_rst
		|=> rst_act_q && wd_st_q == WD_OFF)
		else $error("time-out expiry did not reset");
	a_pin_follow: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		rst_act_q && can_pull |=> !reset_out_low_out)
		else $error("reset active but pin not low");
	a_frame_clear: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		stat_rd && !wdc_wr |=> !frame_err_q)
		else $error("status read did not clear frame error");
	a_wdc_reserved: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		rd_en_in && addr_in == `WDC_OFS |=> rd_data_out[15:5] == 11'h0)
		else $error("reserved watchdog bits read back nonzero");
	a_soft_quiet: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		soft_rst && supp_q && !rst_act_q && filt_cnt_q < RF_CYC && !wd_rst_kick |=> !rst_act_q)
		else $error("suppressed soft reset pulled the pin");
endmodule : reset_and_watchdog_supervisor
`default_nettype wire

/* File: mcu_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// microcontroller as reset receiver
// ----------------------------------------
module mcu_model (
	input wire logic clk_in,
	input wire logic rst_low_in,
	output int falls_out = 0
);
	logic last_q = 1'b0;
	// count reset pulses; the pin idles high, driven by the supervisor
	always @(posedge clk_in) begin
		last_q <= rst_low_in;
		if (last_q === 1'b1 && rst_low_in === 1'b0) begin
			falls_out <= falls_out + 1;
		end
	end
endmodule : mcu_model
`default_nettype wire

/* File: reset_and_watchdog_supervisor_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module reset_and_watchdog_supervisor_tb;
	import supervisor_pkg::*;
	logic clk_in, sys_rst_in, wr_en_in, rd_en_in, thr_ok, v1_ok, por_ok, dev_on, pin;
	logic [7:0] addr_in;
	logic [15:0] wr_data_in, rd_data_out, s;
	int falls, bad_count, checks, cyc;
	// ----------------------------------------
	// design and partner
	// ----------------------------------------
	// short counts keep the run brief: periods 100..800, long window 500
	reset_and_watchdog_supervisor #(
		.WD_PERIOD_CYC({32'h320, 32'h2bc, 32'h258, 32'h1f4, 32'h190, 32'h12c, 32'hc8, 32'h64}),
		.LW_CYC(32'h1f4), .RF_CYC(32'h4), .RD1_CYC(32'h14), .RD2_CYC(32'ha)
	) dut (
		.clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
		.wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
		.main_regulator_output_above_thr_in(thr_ok), .main_regulator_output_above_1v_in(v1_ok), .supply_sense_input_above_por_in(por_ok),
		.sw_dev_mode_in(dev_on), .reset_out_low_out(pin)
	);
	mcu_model partner (.clk_in(clk_in), .rst_low_in(pin), .falls_out(falls));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wr_data_in <= d;
		wr_en_in <= 1'b1;
		@(posedge clk_in);
		wr_en_in <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a);
		@(posedge clk_in);
		addr_in <= a;
		rd_en_in <= 1'b1;
		@(posedge clk_in);
		rd_en_in <= 1'b0;
		#1 s = rd_data_out;
	endtask : rd
	task idle(input int n);
		repeat (n) @(posedge clk_in);
	endtask : idle
	// bounded wait for the reset pin, then compare
	task wait_pin(input logic v, input int n);
		int i;
		i = 0;
		while (pin !== v && i < n) begin
			@(posedge clk_in);
			#1 i++;
		end
		chk(16'(pin), 16'(v));
	endtask : wait_pin
	// even parity over all sixteen bits via bit 15
	function automatic logic [15:0] wd(input logic [4:0] c);
		return {^c, 10'h000, c};
	endfunction : wd
	task done(input string n);
		$display("test %s done", n);
	endtask : done
	task summarize();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : summarize
	// ----------------------------------------
	// clock and hang guard
	// ----------------------------------------
	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			summarize();
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		sys_rst_in = 1'b1;
		{wr_en_in, rd_en_in, thr_ok, dev_on} = 4'h0;
		{v1_ok, por_ok} = 2'h3;
		addr_in = 8'h00;
		wr_data_in = 16'h0000;
		idle(2);
		sys_rst_in <= 1'b0;
		idle(10);
		chk(16'(pin), 16'h0000);
		thr_ok <= 1'b1;
		idle(12);
		chk(16'(pin), 16'h0000);
		wait_pin(1'b1, 20);
		rd(8'h08);
		chk({7'h00, s[8:7], 4'h0, s[2:0]}, 16'h0080);
		wr(8'h00, 16'h0000);
		done("power_up");
		// reserved bit left out of the parity sum must be refused
		wr(8'h04, wd(5'h01) | 16'h0100);
		rd(8'h08);
		chk(16'(s[5]), 16'h0001);
		rd(8'h08);
		chk(16'(s[5]), 16'h0000);
		rd(8'h04);
		chk(16'(s[4:0]), 16'h0000);
		wr(8'h04, wd(5'h01) ^ 16'h8100);
		rd(8'h04);
		chk(16'(s[4:0]), 16'h0001);
		done("parity");
		// time-out: serve every 60 cycles, then stop
		repeat (4) begin
			wr(8'h04, wd(5'h00));
			idle(58);
			chk(16'(pin), 16'h0001);
		end
		wr(8'h04, wd(5'h00));
		idle(90);
		chk(16'(pin), 16'h0001);
		wait_pin(1'b0, 20);
		rd(8'h08);
		chk({11'h000, s[4:3], s[2:0]}, 16'h000c);
		wait_pin(1'b1, 40);
		rd(8'h08);
		chk({7'h00, s[8:7], 4'h0, s[2:0]}, 16'h0081);
		done("timeout");
		// window with fail-safe; triggers spaced 82 then 78 cycles
		wr(8'h04, wd(5'h18));
		rd(8'h08);
		chk(16'(s[4:3]), 16'h0000);
		rd(8'h04);
		chk(16'(s[4:0]), 16'h0018);
		repeat (2) begin
			idle(76);
			wr(8'h04, wd(5'h18));
			chk(16'(pin), 16'h0001);
		end
		idle(20);
		wr(8'h04, wd(5'h18));
		wait_pin(1'b0, 10);
		rd(8'h08);
		chk(16'(s[2:0]), 16'h0005);
		wait_pin(1'b1, 40);
		wr(8'h00, 16'h0000);
		done("window");
		// soft reset with output, refused cases, then a suppressed one without output
		wr(8'h00, 16'h0003);
		wait_pin(1'b0, 10);
		rd(8'h08);
		chk(16'(s[2:0]), 16'h0000);
		wait_pin(1'b1, 40);
		rd(8'h04);
		chk(16'(s[4:0]), 16'h0000);
		wr(8'h04, wd(5'h02));
		rd(8'h04);
		chk(16'(s[4:0]), 16'h0000);
		wr(8'h00, 16'h0003);
		idle(10);
		chk(16'(pin), 16'h0001);
		wr(8'h00, 16'h0004);
		wr(8'h00, 16'h0007);
		idle(10);
		chk(16'(pin), 16'h0001);
		rd(8'h08);
		chk(16'(s[2:0]), 16'h0000);
		done("soft_reset");
		// development mode: a miss restarts the long window
		wr(8'h00, 16'h0000);
		dev_on <= 1'b1;
		wr(8'h04, wd(5'h00));
		idle(150);
		chk(16'(pin), 16'h0001);
		rd(8'h08);
		chk(16'(s[8:7]), 16'h0001);
		dev_on <= 1'b0;
		// stop mode keeps the configuration; serving still works
		wr(8'h00, 16'h0002);
		wr(8'h04, wd(5'h01));
		rd(8'h04);
		chk(16'(s[4:0]), 16'h0000);
		rd(8'h08);
		chk(16'(s[8:7]), 16'h0002);
		wr(8'h00, 16'h0000);
		wr(8'h04, wd(5'h07));
		done("dev_mode");
		// undervoltage: short glitch filtered, long one with second delay
		wr(8'h00, 16'h0008);
		rd(8'h00);
		chk(s, 16'h0008);
		thr_ok <= 1'b0;
		idle(2);
		thr_ok <= 1'b1;
		idle(10);
		chk(16'(pin), 16'h0001);
		thr_ok <= 1'b0;
		wait_pin(1'b0, 20);
		idle(20);
		thr_ok <= 1'b1;
		idle(5);
		chk(16'(pin), 16'h0000);
		wait_pin(1'b1, 15);
		chk(16'(falls), 16'h0004);
		// regulator below 1V: pin cannot be pulled
		v1_ok <= 1'b0;
		thr_ok <= 1'b0;
		idle(30);
		chk(16'(pin), 16'h0001);
		done("undervoltage");
		summarize();
	end
endmodule : reset_and_watchdog_supervisor_tb
`default_nettype wire
